/* logic/twc_pkg.sv */
// constants, types and helpers for the three-wire control slave.
// assumes a 16-bit settings register file and LSB-first byte framing.
package twc_pkg;

  // address byte: transfer type in bits 1:0, device address in bits 7:2
  // 011000 in send order (bit 2 first) reads 6'h06 with bit 7 as msb
  localparam logic [5:0] TWC_DEV_ADDR    = 6'h06;
  localparam logic [1:0] TWC_TYPE_WRITE  = 2'h2;
  localparam logic [1:0] TWC_TYPE_READ   = 2'h3;
  localparam logic [2:0] TWC_LAST_BIT    = 3'h7;

  // register addresses
  localparam logic [6:0] TWC_REG_SYSTEM  = 7'h00;
  localparam logic [6:0] TWC_REG_SOUND   = 7'h10;
  localparam logic [6:0] TWC_REG_VOLUME  = 7'h11;
  localparam logic [6:0] TWC_REG_MUX     = 7'h40;
  localparam logic [6:0] TWC_REG_RESTORE = 7'h7f;
  localparam logic [6:0] TWC_REG_INTERP  = 7'h18;
  localparam logic [6:0] TWC_REG_SPDIF   = 7'h38;

  // reset values
  localparam logic [15:0] TWC_SYSTEM_RST = 16'h2040;
  localparam logic [15:0] TWC_SOUND_RST  = 16'h0001;
  localparam logic [15:0] TWC_VOLUME_RST = 16'h0000;
  localparam logic [15:0] TWC_MUX_RST    = 16'h0002;

  // field positions
  localparam int TWC_PON_POS    = 13;
  localparam int TWC_MODE_POS   = 12;
  localparam int TWC_BASS_POS   = 8;
  localparam int TWC_TREBLE_POS = 3;
  localparam int TWC_DEEMPH_POS = 1;
  localparam int TWC_MUTE_POS   = 0;
  localparam int TWC_VOL_POS    = 0;
  localparam int TWC_AUTOMT_POS = 1;
  localparam int TWC_RSTPLL_POS = 0;
  localparam int TWC_PLLLK_POS  = 10;
  localparam int TWC_SPDLK_POS  = 8;
  localparam int TWC_ASF_POS    = 6;
  localparam int TWC_PCM_POS    = 5;
  localparam int TWC_PRE_POS    = 3;
  localparam int TWC_ACC_POS    = 0;
  localparam int TWC_MTSTAT_POS = 0;

  typedef enum logic [2:0] {
    TWC_ST_IGNORE  = 3'b000,
    TWC_ST_REG     = 3'b001,
    TWC_ST_WR_HI   = 3'b010,
    TWC_ST_WR_LO   = 3'b011,
    TWC_ST_RD_FLAG = 3'b100,
    TWC_ST_RD_HI   = 3'b101,
    TWC_ST_RD_LO   = 3'b110
  } twc_state_type;

  typedef struct packed {
    logic       power_on;
    logic [1:0] filter_mode;
    logic [3:0] bass_boost;
    logic [1:0] treble;
    logic [1:0] deemphasis;
    logic       soft_mute;
    logic [5:0] volume;
    logic       auto_mute;
    logic       pll_reset;
  } twc_settings_type;

  typedef struct packed {
    logic       interp_muted;
    logic       pll_locked;
    logic       spdif_locked;
    logic [1:0] sample_rate_detected;
    logic       pcm_detected;
    logic       pre_emphasis;
    logic [1:0] clock_accuracy;
  } twc_status_type;

  function automatic logic [7:0] twc_rev8(input logic [7:0] value);
    logic [7:0] result;
    result = 8'h00;
    for (int i = 0; i < 8; i++) begin
      result[i] = value[7 - i];
    end
    return result;
  endfunction : twc_rev8

endpackage : twc_pkg

/* logic/twc_slave.sv */
// three-wire serial control slave: link-side decoder and settings file.
// assumes the master clocks the link (rising edge samples, falling edge
// drives), mode and data are synchronous to that clock, status is on clk.
`timescale 1ns/10ps
module twc_slave
  import twc_pkg::*;
#(
  parameter logic [5:0] DEVICE_ADDRESS = TWC_DEV_ADDR
) (
  // system
  input  wire logic             clk,
  input  wire logic             rst,
  // mode strap: high selects static pin control
  input  wire logic             static_mode_select,
  // serial link
  input  wire logic             ctl_serial_clock,
  input  wire logic             ctl_phase_select,
  input  wire logic             ctl_serial_data_in,
  output logic                  ctl_serial_data_out,
  output logic                  ctl_serial_data_oe,
  // device side
  input  wire twc_status_type   status,
  output twc_settings_type      settings
);

  // link-domain reset and mode level, two flops each
  logic lrst_meta_reg, lrst_sync_reg;
  logic lsm_meta_reg, lsm_sync_reg;
  always_ff @(posedge ctl_serial_clock) begin
    lrst_meta_reg <= rst;
    lrst_sync_reg <= lrst_meta_reg;
    lsm_meta_reg  <= static_mode_select;
    lsm_sync_reg  <= lsm_meta_reg;
  end
  // the wake-up pulses carry reset into this domain
  wire link_on = !lrst_sync_reg && !lsm_sync_reg;

  // byte framing
  logic          mode_prev_reg;
  logic [2:0]    bit_cnt_reg;
  logic [7:0]    shift_reg;
  twc_state_type state_reg, state_next;

  wire       mode_edge = ctl_phase_select != mode_prev_reg;
  wire [2:0] bit_idx   = mode_edge ? 3'h0 : bit_cnt_reg;
  wire [7:0] byte_in   = {ctl_serial_data_in, shift_reg[7:1]};
  wire       byte_done = link_on && bit_idx == TWC_LAST_BIT;
  wire       addr_done = byte_done && !ctl_phase_select;
  wire       data_done = byte_done && ctl_phase_select;
  wire       addr_match = byte_in[7:2] == DEVICE_ADDRESS;
  wire [1:0] xfer_type = byte_in[1:0];
  wire [7:0] byte_rev  = twc_rev8(byte_in);
  wire       reg_is_read = byte_rev[7];
  wire [6:0] reg_addr  = byte_rev[6:0];
  wire       reading   = state_reg == TWC_ST_RD_FLAG || state_reg == TWC_ST_RD_HI
                         || state_reg == TWC_ST_RD_LO;

  always_comb begin
    state_next = state_reg;
    if (!link_on) begin
      state_next = TWC_ST_IGNORE;
    end else if (mode_edge && !ctl_phase_select) begin
      state_next = TWC_ST_IGNORE;
    end else if (addr_done) begin
      if (addr_match && xfer_type == TWC_TYPE_WRITE) begin
        state_next = TWC_ST_REG;
      end else if (addr_match && xfer_type == TWC_TYPE_READ) begin
        state_next = TWC_ST_RD_FLAG;
      end else begin
        state_next = TWC_ST_IGNORE;
      end
    end else if (data_done) begin
      unique case (state_reg)
        TWC_ST_IGNORE:  state_next = TWC_ST_IGNORE;
        TWC_ST_REG:     state_next = reg_is_read ? TWC_ST_IGNORE : TWC_ST_WR_HI;
        TWC_ST_WR_HI:   state_next = TWC_ST_WR_LO;
        TWC_ST_WR_LO:   state_next = TWC_ST_IGNORE;
        TWC_ST_RD_FLAG: state_next = TWC_ST_RD_HI;
        TWC_ST_RD_HI:   state_next = TWC_ST_RD_LO;
        TWC_ST_RD_LO:   state_next = TWC_ST_IGNORE;
        default:        state_next = TWC_ST_IGNORE;
      endcase
    end
  end

  always_ff @(posedge ctl_serial_clock) begin
    if (!link_on) begin
      mode_prev_reg <= 1'b0;
      bit_cnt_reg   <= 3'h0;
      shift_reg     <= 8'h00;
    end else begin
      mode_prev_reg <= ctl_phase_select;
      bit_cnt_reg   <= bit_idx + 3'h1;
      shift_reg     <= byte_in;
    end
    state_reg <= state_next;
  end

  // write and prepare capture; hold words stay put until the next
  // transfer, far longer than the clk-side sync needs
  logic [6:0]  reg_sel_reg;
  logic [7:0]  data_hi_reg;
  logic [6:0]  wr_addr_hold_reg;
  logic [15:0] wr_data_hold_reg;
  logic        wr_tgl_reg;
  logic [6:0]  prep_addr_reg;
  logic        prep_tgl_reg;
  logic        prep_pending_reg;
  wire wr_lo_done = data_done && state_reg == TWC_ST_WR_LO;
  wire prep_done  = data_done && state_reg == TWC_ST_REG && reg_is_read;

  always_ff @(posedge ctl_serial_clock) begin
    if (lrst_sync_reg) begin
      reg_sel_reg      <= 7'h00;
      data_hi_reg      <= 8'h00;
      wr_addr_hold_reg <= TWC_REG_RESTORE; // stale post-reset event is harmless
      wr_data_hold_reg <= 16'h0000;
      wr_tgl_reg       <= 1'b0;
      prep_addr_reg    <= 7'h00;
      prep_tgl_reg     <= 1'b0;
      prep_pending_reg <= 1'b0;
    end else begin
      if (data_done && state_reg == TWC_ST_REG) begin
        reg_sel_reg <= reg_addr;
      end
      if (data_done && state_reg == TWC_ST_WR_HI) begin
        data_hi_reg <= byte_rev;
      end
      if (wr_lo_done) begin
        wr_addr_hold_reg <= reg_sel_reg;
        wr_data_hold_reg <= {data_hi_reg, byte_rev};
        wr_tgl_reg       <= !wr_tgl_reg;
      end
      if (prep_done) begin
        prep_addr_reg    <= reg_addr;
        prep_tgl_reg     <= !prep_tgl_reg;
        prep_pending_reg <= 1'b1;
      end else if (addr_done && state_next == TWC_ST_RD_FLAG) begin
        prep_pending_reg <= 1'b0;
      end
    end
  end

  // snapshot coming back from clk: toggle plus held word
  logic        rd_tgl_reg;
  logic        rd_valid_hold_reg;
  logic [15:0] rd_word_hold_reg;
  logic        rt_meta_reg, rt_sync_reg, rt_seen_reg;
  logic        rd_valid_lnk_reg;
  logic [15:0] rd_word_lnk_reg;
  always_ff @(posedge ctl_serial_clock) begin
    rt_meta_reg <= rd_tgl_reg;
    rt_sync_reg <= rt_meta_reg;
    if (lrst_sync_reg) begin
      rt_seen_reg      <= rt_sync_reg;
      rd_valid_lnk_reg <= 1'b0;
      rd_word_lnk_reg  <= 16'h0000;
    end else begin
      rt_seen_reg <= rt_sync_reg;
      if (rt_sync_reg != rt_seen_reg) begin
        rd_valid_lnk_reg <= rd_valid_hold_reg;
        rd_word_lnk_reg  <= rd_word_hold_reg;
      end
    end
  end

  // read answer: flag byte, high byte, low byte, each bit 0 first
  wire       rd_ok     = prep_pending_reg && rd_valid_lnk_reg;
  wire [7:0] flag_byte = twc_rev8({!rd_ok, prep_addr_reg});
  wire [7:0] hi_byte   = twc_rev8(rd_ok ? rd_word_lnk_reg[15:8] : 8'h00);
  wire [7:0] lo_byte   = twc_rev8(rd_ok ? rd_word_lnk_reg[7:0] : 8'h00);
  logic [23:0] tx_word_reg;
  always_ff @(posedge ctl_serial_clock) begin
    if (lrst_sync_reg) begin
      tx_word_reg <= 24'h00_0000;
    end else if (addr_done && state_next == TWC_ST_RD_FLAG) begin
      tx_word_reg <= {lo_byte, hi_byte, flag_byte};
    end else if (reading && ctl_phase_select) begin
      tx_word_reg <= {1'b0, tx_word_reg[23:1]};
    end
  end

  // drive on the falling edge so the master samples a settled bit
  logic tx_bit_reg, tx_oe_reg;
  always_ff @(negedge ctl_serial_clock) begin
    tx_bit_reg <= tx_word_reg[0];
    tx_oe_reg  <= reading && link_on;
  end
  assign ctl_serial_data_out = tx_bit_reg;
  // release at once when mode drops, the master owns the line then
  assign ctl_serial_data_oe  = tx_oe_reg && ctl_phase_select;

  // clk domain: mode level and event toggles
  logic sm_meta_reg, sm_sync_reg;
  logic wt_meta_reg, wt_sync_reg, wt_seen_reg;
  logic pt_meta_reg, pt_sync_reg, pt_seen_reg;
  always_ff @(posedge clk) begin
    sm_meta_reg <= static_mode_select;
    sm_sync_reg <= sm_meta_reg;
    wt_meta_reg <= wr_tgl_reg;
    wt_sync_reg <= wt_meta_reg;
    pt_meta_reg <= prep_tgl_reg;
    pt_sync_reg <= pt_meta_reg;
    wt_seen_reg <= wt_sync_reg;
    pt_seen_reg <= pt_sync_reg;
  end
  wire serial_mode = !sm_sync_reg;
  wire wr_evt      = wt_sync_reg != wt_seen_reg;
  wire prep_evt    = pt_sync_reg != pt_seen_reg;

  // settings file
  logic [15:0] system_reg, sound_reg, volume_reg, mux_reg;
  wire restore = !serial_mode || (wr_evt && wr_addr_hold_reg == TWC_REG_RESTORE);
  always_ff @(posedge clk) begin
    if (rst || restore) begin
      system_reg <= TWC_SYSTEM_RST;
      sound_reg  <= TWC_SOUND_RST;
      volume_reg <= TWC_VOLUME_RST;
      mux_reg    <= TWC_MUX_RST;
    end else if (wr_evt) begin
      if (wr_addr_hold_reg == TWC_REG_SYSTEM) system_reg <= wr_data_hold_reg;
      if (wr_addr_hold_reg == TWC_REG_SOUND)  sound_reg  <= wr_data_hold_reg;
      if (wr_addr_hold_reg == TWC_REG_VOLUME) volume_reg <= wr_data_hold_reg;
      if (wr_addr_hold_reg == TWC_REG_MUX)    mux_reg    <= wr_data_hold_reg;
    end
  end

  twc_settings_type settings_next;
  always_comb begin
    settings_next.power_on    = system_reg[TWC_PON_POS];
    settings_next.filter_mode = sound_reg[TWC_MODE_POS +: 2];
    settings_next.bass_boost  = sound_reg[TWC_BASS_POS +: 4];
    settings_next.treble      = sound_reg[TWC_TREBLE_POS +: 2];
    settings_next.deemphasis  = serial_mode ? sound_reg[TWC_DEEMPH_POS +: 2]
                                            : 2'h0;
    settings_next.soft_mute   = sound_reg[TWC_MUTE_POS];
    settings_next.volume      = volume_reg[TWC_VOL_POS +: 6];
    settings_next.auto_mute   = mux_reg[TWC_AUTOMT_POS];
    settings_next.pll_reset   = mux_reg[TWC_RSTPLL_POS];
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      settings <= '0;
    end else begin
      settings <= settings_next;
    end
  end

  // readable words and prepare-read snapshot
  logic [15:0] interp_word, spdif_word;
  always_comb begin
    interp_word = 16'h0000;
    interp_word[TWC_MTSTAT_POS] = status.interp_muted;
    spdif_word  = 16'h0000;
    spdif_word[TWC_PLLLK_POS]   = status.pll_locked;
    spdif_word[TWC_SPDLK_POS]   = status.spdif_locked;
    spdif_word[TWC_ASF_POS +: 2] = status.sample_rate_detected;
    spdif_word[TWC_PCM_POS]     = status.pcm_detected;
    spdif_word[TWC_PRE_POS]     = status.pre_emphasis;
    spdif_word[TWC_ACC_POS +: 2] = status.clock_accuracy;
  end
  wire is_interp = prep_addr_reg == TWC_REG_INTERP;
  wire is_spdif  = prep_addr_reg == TWC_REG_SPDIF;
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_tgl_reg        <= 1'b0;
      rd_valid_hold_reg <= 1'b0;
      rd_word_hold_reg  <= 16'h0000;
    end else if (prep_evt) begin
      rd_valid_hold_reg <= is_interp || is_spdif;
      rd_word_hold_reg  <= is_spdif ? spdif_word : (is_interp ? interp_word : 16'h0000);
      rd_tgl_reg        <= !rd_tgl_reg;
    end
  end

  // checks, link domain
  unmatched_addr_a: assert property (
    @(posedge ctl_serial_clock) disable iff (lrst_sync_reg)
    addr_done && !addr_match |=> state_reg == TWC_ST_IGNORE)
    else $error("unmatched address not ignored");
  read_entry_a: assert property (
    @(posedge ctl_serial_clock) disable iff (lrst_sync_reg)
    addr_done && addr_match && xfer_type == TWC_TYPE_READ
    |=> state_reg == TWC_ST_RD_FLAG ##0 tx_word_reg[7:0] == $past(flag_byte))
    else $error("read address did not start answer");
  write_entry_a: assert property (
    @(posedge ctl_serial_clock) disable iff (lrst_sync_reg)
    addr_done && addr_match && xfer_type == TWC_TYPE_WRITE |=> state_reg == TWC_ST_REG)
    else $error("write address not accepted");
  mode_abort_a: assert property (
    @(posedge ctl_serial_clock) disable iff (lrst_sync_reg)
    link_on && mode_edge && !ctl_phase_select
    |=> state_reg == TWC_ST_IGNORE && bit_cnt_reg == 3'h1)
    else $error("mode fall did not restart");
  write_hold_a: assert property (
    @(posedge ctl_serial_clock) disable iff (lrst_sync_reg)
    wr_lo_done |=> wr_tgl_reg != $past(wr_tgl_reg)
    && wr_data_hold_reg == {$past(data_hi_reg), $past(byte_rev)})
    else $error("write word not captured");
  prepare_read_a: assert property (
    @(posedge ctl_serial_clock) disable iff (lrst_sync_reg)
    prep_done |=> prep_pending_reg && prep_addr_reg == $past(reg_addr)
    && state_reg == TWC_ST_IGNORE)
    else $error("prepare read not recorded");
  idle_release_a: assert property (
    @(posedge ctl_serial_clock) disable iff (lrst_sync_reg)
    !reading && !$past(reading) |-> !ctl_serial_data_oe)
    else $error("data line driven while idle");

  // checks, clk domain
  restore_defaults_a: assert property (
    @(posedge clk) disable iff (rst)
    wr_evt && wr_addr_hold_reg == TWC_REG_RESTORE
    |=> sound_reg == TWC_SOUND_RST && mux_reg == TWC_MUX_RST)
    else $error("restore did not reload defaults");
  deemph_gate_a: assert property (
    @(posedge clk) disable iff (rst)
    !serial_mode |=> settings.deemphasis == 2'h0)
    else $error("de-emphasis active outside serial mode");
  static_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    !serial_mode ##1 !serial_mode |-> system_reg == TWC_SYSTEM_RST
    && volume_reg == TWC_VOLUME_RST)
    else $error("settings changed in static mode");

endmodule : twc_slave

/* bench/twc_master.sv */
// serial bus master model that drives the link of the control slave.
// assumes the bench calls its tasks in order; the link clock idles high.
`timescale 1ns/10ps
module twc_master (
  // link toward the slave
  output logic ctl_serial_clock,
  output logic ctl_phase_select,
  output logic ctl_serial_data_in,
  // slave drive of the shared data line
  input  wire logic ctl_serial_data_out,
  input  wire logic ctl_serial_data_oe
);
  localparam time HALF = 32ns;
  logic drive_bit;
  logic drive_en;
  logic last_level;

  // no pull on the line: a released line shows the inverse of its last level
  assign ctl_serial_data_in = ctl_serial_data_oe ? ctl_serial_data_out
                            : (drive_en ? drive_bit : ~last_level);

  always @(posedge ctl_serial_clock) last_level <= ctl_serial_data_in;

  initial begin
    ctl_serial_clock = 1'b1;
    ctl_phase_select = 1'b0;
    drive_bit        = 1'b0;
    drive_en         = 1'b1;
    last_level       = 1'b0;
  end

  // data and mode change with the falling edge, slave samples on rising
  task automatic pulse(input logic mode, input logic bit_val);
    ctl_phase_select = mode;
    drive_en         = 1'b1;
    drive_bit        = bit_val;
    ctl_serial_clock = 1'b0;
    #(HALF);
    ctl_serial_clock = 1'b1;
    #(HALF);
  endtask : pulse

  // mode held high so the wake pulses never count as address bits
  task automatic wake(input int count);
    repeat (count) pulse(1'b1, 1'b0);
  endtask : wake

  task automatic send_byte(input logic mode, input logic [7:0] value);
    for (int i = 0; i < 8; i++) begin
      pulse(mode, value[i]);
    end
  endtask : send_byte

  task automatic recv_byte(output logic [7:0] value);
    value = 8'h00;
    for (int i = 0; i < 8; i++) begin
      ctl_phase_select = 1'b1;
      drive_en         = 1'b0;
      ctl_serial_clock = 1'b0;
      #(HALF);
      ctl_serial_clock = 1'b1;
      value[i]         = ctl_serial_data_in;
      #(HALF);
    end
  endtask : recv_byte

  task automatic end_read();
    ctl_phase_select = 1'b0;
    drive_en         = 1'b1;
  endtask : end_read

endmodule : twc_master

/* bench/three_wire_control_slave_tb.sv */
// self-checking bench for the three-wire control slave.
// assumes twc_master drives the link; strap, status and reset are driven here.
`timescale 1ns/10ps
module three_wire_control_slave_tb
  import twc_pkg::*;
;
  logic             clk;
  logic             rst;
  logic             static_mode_select;
  logic             sclk;
  logic             mode;
  logic             sdi;
  logic             sdo;
  logic             soe;
  twc_status_type   status;
  twc_settings_type settings;
  int               error_cnt;
  int               checked;
  int               cycle_cnt;
  logic             oe_seen;
  twc_settings_type exp_set;

  twc_slave #(.DEVICE_ADDRESS(TWC_DEV_ADDR)) dut (
    .clk(clk), .rst(rst), .static_mode_select(static_mode_select),
    .ctl_serial_clock(sclk), .ctl_phase_select(mode), .ctl_serial_data_in(sdi),
    .ctl_serial_data_out(sdo), .ctl_serial_data_oe(soe),
    .status(status), .settings(settings)
  );

  twc_master mst (
    .ctl_serial_clock(sclk), .ctl_phase_select(mode), .ctl_serial_data_in(sdi),
    .ctl_serial_data_out(sdo), .ctl_serial_data_oe(soe)
  );

  initial begin
    clk                = 1'b0;
    rst                = 1'b1;
    static_mode_select = 1'b0;
    status             = '0;
    error_cnt          = 0;
    checked            = 0;
    cycle_cnt          = 0;
    oe_seen            = 1'b0;
  end

  always #50 clk = ~clk;
  always @(posedge soe) oe_seen = 1'b1;

  // cut a hang short well beyond the expected run of under 1000 cycles
  always @(posedge clk) begin
    cycle_cnt++;
    if (cycle_cnt == 5000) begin
      error_cnt++;
      final_report();
    end
  end

  function automatic logic [7:0] flip8(input logic [7:0] x);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = x[7 - i];
    return r;
  endfunction : flip8

  // register byte: direction first in time, then A6 down to A0
  function automatic logic [7:0] regb(input logic [6:0] a, input logic dir);
    logic [7:0] r;
    r[0] = dir;
    for (int i = 0; i < 7; i++) r[i + 1] = a[6 - i];
    return r;
  endfunction : regb

  function automatic twc_settings_type defaults();
    twc_settings_type s;
    s           = '0;
    s.power_on  = 1'b1;
    s.soft_mute = 1'b1;
    s.auto_mute = 1'b1;
    return s;
  endfunction : defaults

  task automatic cmp_set(input string name, input twc_settings_type exp);
    checked++;
    if (settings !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, settings);
    end
  endtask : cmp_set

  task automatic cmp_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_byte

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  // settings settle within 5 clk cycles of the last bit; 10 leaves margin
  task automatic wr(input logic [7:0] ab, input logic [6:0] a, input logic [15:0] d);
    mst.send_byte(1'b0, ab);
    mst.send_byte(1'b1, regb(a, 1'b0));
    mst.send_byte(1'b1, flip8(d[15:8]));
    mst.send_byte(1'b1, flip8(d[7:0]));
    wait_clk(10);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic prep, input logic flag,
                    input logic [15:0] d);
    logic [7:0] r0;
    logic [7:0] r1;
    logic [7:0] r2;
    if (prep) begin
      mst.send_byte(1'b0, 8'h1a);
      mst.send_byte(1'b1, regb(a, 1'b1));
      #2us;
    end
    mst.send_byte(1'b0, 8'h1b);
    mst.recv_byte(r0);
    mst.recv_byte(r1);
    mst.recv_byte(r2);
    mst.end_read();
    // let the released enable settle before it is looked at
    #1us;
    if (prep) cmp_byte("flag_addr", regb(a, flag), r0);
    else cmp_byte("flag", {7'h00, flag}, {7'h00, r0[0]});
    cmp_byte("data_hi", flip8(d[15:8]), r1);
    cmp_byte("data_lo", flip8(d[7:0]), r2);
    cmp_byte("oe_released", 8'h00, {7'h00, soe});
  endtask : rd

  task automatic t_write();
    twc_settings_type e;
    e = defaults();
    wr(8'h1a, 7'h40, 16'h0003);
    e.pll_reset = 1'b1;
    cmp_set("init_mux", e);
    wr(8'h1a, 7'h7f, 16'h0000);
    e = defaults();
    cmp_set("init_restore", e);
    wr(8'h1a, 7'h10, 16'h2b0e);
    {e.filter_mode, e.bass_boost, e.treble, e.deemphasis, e.soft_mute} = 11'h56e;
    cmp_set("sound", e);
    wr(8'h1a, 7'h11, 16'hffe5);
    e.volume = 6'h25;
    cmp_set("volume", e);
    exp_set = e;
    $display("test write done");
  endtask : t_write

  task automatic t_refused();
    twc_settings_type e;
    logic [7:0] bad [4];
    e       = exp_set;
    bad     = '{8'h18, 8'h19, 8'h1e, 8'h1f};
    oe_seen = 1'b0;
    foreach (bad[i]) wr(bad[i], 7'h11, 16'h0015);
    cmp_set("refused", e);
    cmp_byte("oe_seen", 8'h00, {7'h00, oe_seen});
    $display("test refused done");
  endtask : t_refused

  task automatic t_abort();
    twc_settings_type e;
    e = exp_set;
    mst.send_byte(1'b0, 8'h1a);
    mst.send_byte(1'b1, regb(7'h11, 1'b0));
    repeat (4) mst.pulse(1'b1, 1'b1);
    wr(8'h1a, 7'h11, 16'h0011);
    e.volume = 6'h11;
    cmp_set("abort", e);
    wr(8'h1a, 7'h7f, 16'h0000);
    cmp_set("restore", defaults());
    $display("test abort_restore done");
  endtask : t_abort

  task automatic t_read();
    @(posedge clk);
    status <= '{interp_muted: 1'b1, pll_locked: 1'b1, spdif_locked: 1'b0,
                sample_rate_detected: 2'h2, pcm_detected: 1'b1, pre_emphasis: 1'b1,
                clock_accuracy: 2'h1};
    wait_clk(5);
    rd(7'h38, 1'b1, 1'b0, 16'h04a9);
    rd(7'h38, 1'b0, 1'b1, 16'h0000);
    rd(7'h18, 1'b1, 1'b0, 16'h0001);
    rd(7'h11, 1'b1, 1'b1, 16'h0000);
    $display("test read done");
  endtask : t_read

  task automatic t_static();
    twc_settings_type e;
    @(posedge clk);
    static_mode_select <= 1'b1;
    wait_clk(10);
    wr(8'h1a, 7'h10, 16'h0006);
    cmp_set("static_hold", defaults());
    static_mode_select <= 1'b0;
    wait_clk(10);
    // the link side resyncs the strap only on link clocks
    mst.wake(4);
    wr(8'h1a, 7'h10, 16'h0006);
    e            = defaults();
    e.deemphasis = 2'h3;
    e.soft_mute  = 1'b0;
    cmp_set("serial_again", e);
    $display("test static done");
  endtask : t_static

  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    // link domain takes reset through its own clock, so pulse it meanwhile
    fork
      mst.wake(4);
      wait_clk(3);
    join
    @(posedge clk);
    rst <= 1'b0;
    wait_clk(2);
    mst.wake(4);
    wait_clk(3);
    t_write();
    t_refused();
    t_abort();
    t_read();
    t_static();
    final_report();
  end

endmodule : three_wire_control_slave_tb
